// *** spf_button_model.sv ***
// pushbuttons with pull-ups on the eight lower pins
`timescale 1ns/1ps
module spf_button_model (
  input wire logic [7:0] press_i,
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  output logic [7:0] level_o
);
  // ****************************************
  // wire level
  // ****************************************
  // undriven pin rests high; a pressed button pulls it low
  always_comb begin
    level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ~press_i);
  end
endmodule

// *** spf_pin_func.sv ***
// selectable pin function logic for the eight lower pins
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - any function on any lower pin, configured
// - output shared by pins, per-pin open-drain
// - logic drives pins, level still readable
// - eleven input functions offered
// - eight output functions, two polarities
// - media buttons debounced, press/release reports
// - accept level after full debounce interval
// - capture mute flips on debounced release
// - three fixed profiles plus host profile
// - cycle to next non-blank profile
// - selected profile index saved nonvolatile
// - apply selected profile at stream start
// - classify long, single, double, triple
// - map each tap kind to a function
// - sleep outputs follow bus suspend exactly
// - suspend when detached or bus stopped
// - saving outputs follow low-power mode
// - low power only when audio, serial idle
// - capture outputs follow capture mute state
// - playback outputs follow host mute command
// - configuration size capped, fields unconstrained
// - legal stream selections plus sync mode
module spf_pin_func (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire spf_pkg::spf_axi_req_type AXI_REQ_I,
  output spf_pkg::spf_axi_resp_type AXI_RESP_O,
  input wire logic [7:0] PIN_IN_I,
  output logic [7:0] PIN_OUT_O,
  output logic [7:0] PIN_OE_O,
  input wire logic USB_ATTACHED_I,
  input wire logic USB_BUS_IDLE_I,
  input wire logic AUDIO_IDLE_I,
  input wire logic SERIAL_IDLE_I,
  input wire logic PLAYBACK_MUTE_I,
  input wire logic STREAM_START_I,
  input wire logic [1:0] NV_PROFILE_I,
  output logic NV_SAVE_O,
  output logic PROFILE_APPLY_O,
  output logic [1:0] PROFILE_IDX_O,
  output logic [4:0] AUDIO_MODE_O,
  output spf_pkg::spf_hid_type HID_O
);
  import spf_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] sync1; // first synchroniser stage
    logic [7:0] sync2; // second synchroniser stage
    logic [7:0] stable; // debounced pin levels
    logic [7:0][15:0] cnt; // per-pin debounce counters
    logic [7:0][4:0] sel; // function code per pin
    logic [7:0] od; // open-drain per pin
    logic [7:0] gdir; // plain pin output enable
    logic [7:0] gval; // plain pin output value
    logic [3:0][3:0] tap_map; // function per tap kind
    logic [15:0] debounce; // debounce interval
    logic [15:0] hold; // long press hold time
    logic [15:0] gap; // inter-click timeout
    logic [3:0] mask; // non-blank profiles
    logic [1:0] prof_idx; // selected profile
    logic loaded; // stored index restored
    logic [3:0] stream; // stream selection
    logic async_mode; // synchronisation mode
    logic [15:0] cfg_size; // configuration image size
    spf_tap_type tap_state; // multi-press classifier
    logic [15:0] tap_cnt; // hold or gap timer
    logic [1:0] clicks; // clicks in sequence
    logic tap_long; // long press already fired
    logic [7:0] pend_p; // pending press reports
    logic [7:0] pend_r; // pending release reports
    logic sleep; // bus suspend
    logic saving; // low-power mode
    logic capt_mute; // capture mute state
    logic play_mute; // playback mute state
    logic [7:0] pin_out; // registered pin values
    logic [7:0] pin_oe; // registered pin enables
    logic nv_save; // store pulse
    logic prof_apply; // apply pulse
    spf_hid_type hid; // report strobe
    logic aw_have; // write address held
    logic w_have; // write data held
    logic [7:0] awaddr; // held write address
    logic [31:0] wdata; // held write data
    logic [3:0] wstrb; // held strobes
    spf_axi_resp_type resp; // bus answer
  } spf_state_type;

  spf_state_type s; // current state
  spf_state_type n; // next state

  logic [7:0] fall; // debounced press edges
  logic [7:0] rise; // debounced release edges
  logic tap_down; // multi-press button held
  logic fire; // tap kind recognised
  logic [1:0] kind; // 0 long, 1..3 clicks
  logic [8:0][4:0] codes; // pins plus tap source
  logic [8:0] pe; // press events per source
  logic [8:0] re; // release events per source
  logic [7:0] press_req; // new press requests
  logic [7:0] rel_req; // new release requests
  logic capt_tog; // flip capture mute
  logic prof_adv; // advance profile
  logic found; // search hit
  logic [1:0] cand; // profile candidate
  logic [7:0] out_fn; // output function sources
  logic val; // pin value
  logic drive; // pin driven
  logic [32:0] rd_w; // hit and word at write address
  logic [32:0] rd_r; // hit and word at read address
  logic [31:0] wv; // merged write word
  logic werr; // write answered with error

  // ****************************************
  // register read decode
  // ****************************************
  // returns hit flag above the register word
  function automatic logic [32:0] spf_read(input spf_state_type st,
                                          input logic [7:0] a);
    logic [31:0] d;
    logic hit;
    d = '0;
    hit = 1'b1;
    case ({a[7:2], 2'b00})
      PIN_SEL_LO_OFS: begin
        for (int k = 0; k < 4; k++) begin
          d[k*SEL_STRIDE +: SEL_W] = st.sel[k];
        end
      end
      PIN_SEL_HI_OFS: begin
        for (int k = 0; k < 4; k++) begin
          d[k*SEL_STRIDE +: SEL_W] = st.sel[k+4];
        end
      end
      PIN_MODE_OFS: begin
        d[7:0] = st.od;
        d[MODE_DIR_POS +: 8] = st.gdir;
        d[MODE_VAL_POS +: 8] = st.gval;
      end
      TAP_MAP_OFS: d[15:0] = st.tap_map;
      DEBOUNCE_OFS: d[15:0] = st.debounce;
      TAP_TIMING_OFS: begin
        d[15:0] = st.hold;
        d[TIMING_GAP_POS +: 16] = st.gap;
      end
      PROFILE_OFS: begin
        d[3:0] = st.mask;
        d[PROFILE_IDX_POS +: 2] = st.prof_idx;
      end
      AUDIO_CFG_OFS: begin
        d[3:0] = st.stream;
        d[AUDIO_ASYNC_POS] = st.async_mode;
      end
      CFG_SIZE_OFS: d[15:0] = st.cfg_size;
      STATUS_OFS: begin
        d[7:0] = st.sync2;
        d[STAT_SLEEP_POS] = st.sleep;
        d[STAT_SAVING_POS] = st.saving;
        d[STAT_CAPT_POS] = st.capt_mute;
        d[STAT_PLAY_POS] = st.play_mute;
        d[STAT_TAP_POS] = (st.tap_state != TAP_IDLE);
      end
      default: hit = 1'b0; // unmapped: error answer
    endcase
    return {hit, d};
  endfunction

  // byte-lane merge of a write into the old word
  function automatic logic [31:0] spf_merge(input logic [31:0] o,
                                           input logic [31:0] d,
                                           input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) begin
        r[k*8 +: 8] = d[k*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    fall = '0;
    rise = '0;
    fire = 1'b0;
    kind = 2'h0;
    press_req = '0;
    rel_req = '0;
    capt_tog = 1'b0;
    prof_adv = 1'b0;
    found = 1'b0;
    cand = 2'h0;
    val = 1'b0;
    drive = 1'b0;
    wv = '0;
    werr = 1'b0;
    n.hid.valid = 1'b0;
    n.prof_apply = 1'b0;
    n.nv_save = 1'b0;
    rd_w = spf_read(s, s.awaddr);
    rd_r = spf_read(s, AXI_REQ_I.araddr);

    // pins cross into the clock domain first
    n.sync1 = PIN_IN_I;
    n.sync2 = s.sync1;

    // restore stored selection once after reset
    if (!s.loaded) begin
      n.loaded = 1'b1;
      n.prof_idx = NV_PROFILE_I;
    end

    // debounce: a new level must persist the whole interval
    for (int i = 0; i < 8; i++) begin
      if (s.sync2[i] == s.stable[i]) begin
        n.cnt[i] = '0; // bounce restarts the interval
      end else if ({1'b0, s.cnt[i]} + 17'h00001 >=
                   {1'b0, s.debounce}) begin
        n.stable[i] = s.sync2[i];
        n.cnt[i] = '0;
        fall[i] = s.stable[i];
        rise[i] = ~s.stable[i];
      end else begin
        n.cnt[i] = s.cnt[i] + 16'h0001;
      end
    end

    // multi-press button is held while any of its pins is low
    tap_down = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (s.sel[i] == FN_MULTI_PRESS && !s.stable[i]) begin
        tap_down = 1'b1;
      end
    end

    // tap classifier: hold time splits long press from clicks
    case (s.tap_state)
      TAP_IDLE: begin
        if (tap_down) begin
          n.tap_state = TAP_DOWN;
          n.tap_cnt = '0;
          n.clicks = 2'h0;
        end
      end
      TAP_DOWN: begin
        if (!tap_down) begin
          n.tap_cnt = '0;
          if (s.tap_long) begin
            n.tap_long = 1'b0; // long press ends quietly
            n.tap_state = TAP_IDLE;
          end else begin
            // more than three clicks count as triple
            n.clicks = (s.clicks == 2'h3) ? 2'h3 : s.clicks + 2'h1;
            n.tap_state = TAP_GAP;
          end
        end else if (!s.tap_long && s.tap_cnt >= s.hold) begin
          fire = 1'b1;
          kind = 2'h0;
          n.tap_long = 1'b1;
        end else if (!s.tap_long) begin
          n.tap_cnt = s.tap_cnt + 16'h0001;
        end
      end
      TAP_GAP: begin
        if (tap_down) begin
          n.tap_state = TAP_DOWN;
          n.tap_cnt = '0;
        end else if (s.tap_cnt >= s.gap) begin
          fire = 1'b1;
          kind = s.clicks;
          n.tap_state = TAP_IDLE;
        end else begin
          n.tap_cnt = s.tap_cnt + 16'h0001;
        end
      end
      default: n.tap_state = TAP_IDLE;
    endcase

    // sources: eight pins, then the recognised tap
    codes[7:0] = s.sel;
    codes[8] = {1'b0, s.tap_map[kind]};
    pe = {fire, fall};
    re = {fire, rise};
    for (int i = 0; i < 9; i++) begin
      if (codes[i] >= FN_PLAY_PAUSE && codes[i] <= FN_STOP) begin
        press_req[3'(codes[i] - FN_PLAY_PAUSE)] |= pe[i];
        rel_req[3'(codes[i] - FN_PLAY_PAUSE)] |= re[i];
      end else if (codes[i] == FN_CAPTURE_TOGGLE) begin
        capt_tog |= re[i];
      end else if (codes[i] == FN_PROFILE_CYCLE) begin
        prof_adv |= pe[i];
      end
    end

    // reports wait in pending bits; a new request beats a clear
    n.pend_p = s.pend_p | press_req;
    n.pend_r = s.pend_r | rel_req;
    for (int j = 0; j < 8; j++) begin
      if (!found && s.pend_p[j]) begin
        found = 1'b1;
        n.hid.valid = 1'b1;
        n.hid.pressed = 1'b1;
        n.hid.usage = 3'(j);
        n.pend_p[j] = press_req[j];
      end
    end
    // presses go first so a tap never releases before it presses
    for (int j = 0; j < 8; j++) begin
      if (!found && s.pend_r[j]) begin
        found = 1'b1;
        n.hid.valid = 1'b1;
        n.hid.pressed = 1'b0;
        n.hid.usage = 3'(j);
        n.pend_r[j] = rel_req[j];
      end
    end

    if (capt_tog) begin
      n.capt_mute = ~s.capt_mute;
    end

    // profile cycle over 0..3, blank ones skipped
    found = 1'b0;
    if (prof_adv) begin
      for (int k = 1; k < 5; k++) begin
        cand = s.prof_idx + 2'(k);
        if (!found && s.mask[cand]) begin
          found = 1'b1;
          n.prof_idx = cand;
        end
      end
      n.prof_apply = found;
      n.nv_save = found;
    end
    if (STREAM_START_I) begin
      n.prof_apply = 1'b1;
    end

    // power and mute states from the surrounding device
    n.sleep = ~USB_ATTACHED_I | USB_BUS_IDLE_I;
    n.saving = AUDIO_IDLE_I & SERIAL_IDLE_I;
    n.play_mute = PLAYBACK_MUTE_I;

    // one source per output function, shared by all its pins
    out_fn = {~n.play_mute, n.play_mute,
              ~n.capt_mute, n.capt_mute,
              ~n.saving, n.saving,
              ~n.sleep, n.sleep};
    for (int i = 0; i < 8; i++) begin
      val = 1'b0;
      drive = 1'b0;
      if (s.sel[i] >= FN_OUT_BASE && s.sel[i] <= FN_OUT_LAST) begin
        val = out_fn[3'(s.sel[i] - FN_OUT_BASE)];
        drive = 1'b1;
      end else if (s.sel[i] == FN_NONE) begin
        val = s.gval[i];
        drive = s.gdir[i];
      end
      // open drain only pulls low, else released
      n.pin_out[i] = val & ~s.od[i];
      n.pin_oe[i] = drive & (~s.od[i] | ~val);
    end

    // ****************************************
    // bus slave
    // ****************************************
    if (s.resp.bvalid && AXI_REQ_I.bready) begin
      n.resp.bvalid = 1'b0;
    end
    if (s.resp.awready && AXI_REQ_I.awvalid) begin
      n.aw_have = 1'b1;
      n.awaddr = AXI_REQ_I.awaddr;
    end
    if (s.resp.wready && AXI_REQ_I.wvalid) begin
      n.w_have = 1'b1;
      n.wdata = AXI_REQ_I.wdata;
      n.wstrb = AXI_REQ_I.wstrb;
    end
    // write once both halves are in and no answer is pending
    if (s.aw_have && s.w_have && !s.resp.bvalid) begin
      wv = spf_merge(rd_w[31:0], s.wdata, s.wstrb);
      werr = ~rd_w[32];
      case ({s.awaddr[7:2], 2'b00})
        PIN_SEL_LO_OFS: begin
          for (int k = 0; k < 4; k++) begin
            n.sel[k] = wv[k*SEL_STRIDE +: SEL_W];
          end
        end
        PIN_SEL_HI_OFS: begin
          for (int k = 0; k < 4; k++) begin
            n.sel[k+4] = wv[k*SEL_STRIDE +: SEL_W];
          end
        end
        PIN_MODE_OFS: begin
          n.od = wv[7:0];
          n.gdir = wv[MODE_DIR_POS +: 8];
          n.gval = wv[MODE_VAL_POS +: 8];
        end
        TAP_MAP_OFS: n.tap_map = wv[15:0];
        DEBOUNCE_OFS: n.debounce = wv[15:0];
        TAP_TIMING_OFS: begin
          n.hold = wv[15:0];
          n.gap = wv[TIMING_GAP_POS +: 16];
        end
        PROFILE_OFS: n.mask = wv[3:0];
        AUDIO_CFG_OFS: begin
          if (wv[3:0] > STREAM_LAST) begin
            werr = 1'b1;
          end else begin
            n.stream = wv[3:0];
            n.async_mode = wv[AUDIO_ASYNC_POS];
          end
        end
        CFG_SIZE_OFS: begin
          if (wv[15:0] > CFG_LIMIT) begin
            werr = 1'b1;
          end else begin
            n.cfg_size = wv[15:0];
          end
        end
        default: ; // status is read-only
      endcase
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.resp.bvalid = 1'b1;
      n.resp.bresp = werr ? AXI_SLVERR : AXI_OKAY;
    end
    n.resp.awready = ~n.aw_have;
    n.resp.wready = ~n.w_have;

    // reads answer one cycle after the address is taken
    if (s.resp.rvalid && AXI_REQ_I.rready) begin
      n.resp.rvalid = 1'b0;
      n.resp.arready = 1'b1;
    end
    if (s.resp.arready && AXI_REQ_I.arvalid) begin
      n.resp.arready = 1'b0;
      n.resp.rvalid = 1'b1;
      n.resp.rdata = rd_r[31:0];
      n.resp.rresp = rd_r[32] ? AXI_OKAY : AXI_SLVERR;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // idle-high pin reset avoids a false press after reset
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s <= '0;
      s.sync1 <= 8'hFF;
      s.sync2 <= 8'hFF;
      s.stable <= 8'hFF;
      s.debounce <= DEBOUNCE_RST;
      s.hold <= HOLD_RST;
      s.gap <= GAP_RST;
      s.mask <= PROFILE_MASK_RST;
      s.tap_state <= TAP_IDLE;
      s.resp.awready <= 1'b1;
      s.resp.wready <= 1'b1;
      s.resp.arready <= 1'b1;
    end else if (CE_I) begin
      s <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign AXI_RESP_O = s.resp;
  assign PIN_OUT_O = s.pin_out;
  assign PIN_OE_O = s.pin_oe;
  assign NV_SAVE_O = s.nv_save;
  assign PROFILE_APPLY_O = s.prof_apply;
  assign PROFILE_IDX_O = s.prof_idx;
  assign AUDIO_MODE_O = {s.async_mode, s.stream};
  assign HID_O = s.hid;

endmodule

// *** spf_pin_func_sva.sv ***
// bus answer and profile pulse checker for the pin function block
`timescale 1ns/1ps
module spf_pin_func_sva (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire spf_pkg::spf_axi_req_type AXI_REQ_I,
  input wire spf_pkg::spf_axi_resp_type AXI_RESP_O,
  input wire logic STREAM_START_I,
  input wire logic NV_SAVE_O,
  input wire logic PROFILE_APPLY_O,
  input wire logic [4:0] AUDIO_MODE_O,
  input wire spf_pkg::spf_hid_type HID_O
);
  import spf_pkg::*;
  // ****************************************
  // assertions, one clock domain
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // both write channels taken at once while no answer pends
  sequence wr_take;
    AXI_REQ_I.awvalid && AXI_RESP_O.awready && AXI_REQ_I.wvalid &&
    AXI_RESP_O.wready && !AXI_RESP_O.bvalid && CE_I ##1 CE_I;
  endsequence
  chk_read_answer: assert property (AXI_REQ_I.arvalid &&
    AXI_RESP_O.arready && CE_I |=> AXI_RESP_O.rvalid)
    else $error("read answer late");
  chk_read_stands: assert property (AXI_RESP_O.rvalid &&
    !AXI_REQ_I.rready |=> AXI_RESP_O.rvalid && $stable(AXI_RESP_O.rdata))
    else $error("read data dropped");
  chk_write_stands: assert property (AXI_RESP_O.bvalid &&
    !AXI_REQ_I.bready |=> AXI_RESP_O.bvalid && $stable(AXI_RESP_O.bresp))
    else $error("write answer dropped");
  chk_write_answer: assert property (wr_take |=> AXI_RESP_O.bvalid)
    else $error("write answer late");
  chk_refuse_zero: assert property (AXI_RESP_O.rvalid &&
    AXI_RESP_O.rresp == AXI_SLVERR |-> AXI_RESP_O.rdata == 32'h0)
    else $error("refused read carries data");
  chk_stream_apply: assert property (STREAM_START_I && CE_I
    |=> PROFILE_APPLY_O) else $error("profile not applied");
  chk_save_apply: assert property (NV_SAVE_O |-> PROFILE_APPLY_O)
    else $error("saved index not applied");
  chk_stream_legal: assert property (AUDIO_MODE_O[3:0] <=
    STREAM_LAST) else $error("illegal stream selection");
  // main scenarios seen
  cover property (HID_O.valid && HID_O.pressed);
  cover property (NV_SAVE_O);
  cover property (AXI_RESP_O.bvalid && AXI_RESP_O.bresp == AXI_SLVERR);
endmodule
bind spf_pin_func spf_pin_func_sva chk (.CORE_CLK_I, .RST_N_I, .CE_I,
  .AXI_REQ_I, .AXI_RESP_O, .STREAM_START_I, .NV_SAVE_O,
  .PROFILE_APPLY_O, .AUDIO_MODE_O, .HID_O);

// *** spf_pin_func_test.sv ***
// self-checking bench of the selectable pin function block
`timescale 1ns/1ps
module spf_pin_func_test;
  import spf_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk, rst_n, ce, att, bidle, aud, ser, pm, ss, save, apply;
  logic [1:0] nv, pidx;
  logic [7:0] btn, lvl, pout, poe;
  logic [4:0] amode;
  spf_axi_req_type rq;
  spf_axi_resp_type rs;
  spf_hid_type hid;
  int err_total, compares;
  spf_pin_func uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .AXI_REQ_I(rq), .AXI_RESP_O(rs), .PIN_IN_I(lvl), .PIN_OUT_O(pout),
    .PIN_OE_O(poe), .USB_ATTACHED_I(att), .USB_BUS_IDLE_I(bidle),
    .AUDIO_IDLE_I(aud), .SERIAL_IDLE_I(ser), .PLAYBACK_MUTE_I(pm),
    .STREAM_START_I(ss), .NV_PROFILE_I(nv), .NV_SAVE_O(save),
    .PROFILE_APPLY_O(apply), .PROFILE_IDX_O(pidx), .AUDIO_MODE_O(amode),
    .HID_O(hid));
  spf_button_model btns (.press_i(btn), .pin_out_i(pout), .pin_oe_i(poe),
    .level_o(lvl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  // wide enough for response code above read data
  task cmp(input logic [63:0] g, input logic [63:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("Error at %0t got %h expected %h", $time, g, x);
    end
  endtask
  // both write channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (!rs.bvalid);
    cmp(rs.bresp, e);
    rq.bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (!rs.rvalid);
    cmp({rs.rresp, rs.rdata}, {e, d});
    rq.rready <= 1'b0;
  endtask
  // bounded wait for a report; a missing one shows as valid 0
  task hidw(input logic p, input logic [2:0] u);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hid.valid !== 1'b1 && n < 300);
    cmp(hid, {1'b1, p, u});
  endtask
  task push(input int k, input logic v);
    @(posedge clk);
    btn[k] <= v;
    repeat (12) @(posedge clk);
  endtask
  task savew(input logic [1:0] x);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (save !== 1'b1 && n < 300);
    cmp({save, apply, pidx}, {2'b11, x});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    rd(DEBOUNCE_OFS, DEBOUNCE_RST, AXI_OKAY);
    rd(TAP_TIMING_OFS, {GAP_RST, HOLD_RST}, AXI_OKAY);
    rd(PROFILE_OFS, 32'h21, AXI_OKAY);
    rd(8'h30, 32'h0, AXI_SLVERR);
    wr(8'h30, 32'h1, AXI_SLVERR);
    wr(AUDIO_CFG_OFS, 32'h8, AXI_SLVERR);
    for (int i = 0; i < 8; i++) begin
      wr(AUDIO_CFG_OFS, {i[0], i[3:0]}, AXI_OKAY);
      cmp(amode, {i[0], i[3:0]});
    end
    wr(CFG_SIZE_OFS, 32'hAF1, AXI_SLVERR);
    wr(CFG_SIZE_OFS, 32'hAF0, AXI_OKAY);
    rd(CFG_SIZE_OFS, 32'hAF0, AXI_OKAY);
  endtask
  // all output functions, pin 1 open-drain
  task t_outs;
    logic sl, sv;
    logic [7:0] ev;
    wr(PIN_SEL_LO_OFS, 32'h13120D0C, AXI_OKAY);
    wr(PIN_SEL_HI_OFS, 32'h11100F0E, AXI_OKAY);
    wr(PIN_MODE_OFS, 32'h2, AXI_OKAY);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      att <= i[0];
      bidle <= i[1];
      aud <= i[2];
      ser <= i[1];
      pm <= i[0];
      repeat (4) @(posedge clk);
      sl = !i[0] | i[1];
      sv = i[2] & i[1];
      ev = {2'b10, !sv, sv, !i[0], i[0], !sl, sl};
      cmp({poe, pout}, {6'h3F, sl, 1'b1, ev & 8'hFD});
      rd(STATUS_OFS, {20'h0, i[0], 1'b0, sv, sl, ev}, AXI_OKAY);
    end
  endtask
  task t_buttons;
    wr(PIN_MODE_OFS, 32'h0, AXI_OKAY);
    // pins leave their output roles while the long interval still
    // hides their low levels, so no stale edge reaches an input role
    wr(PIN_SEL_LO_OFS, 32'h0A090B01, AXI_OKAY);
    wr(PIN_SEL_HI_OFS, 32'h1010, AXI_OKAY);
    wr(DEBOUNCE_OFS, 32'h2, AXI_OKAY);
    @(posedge clk);
    btn[0] <= 1'b1;
    @(posedge clk);
    btn[0] <= 1'b0;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      if (hid.valid !== 1'b0) cmp(hid, 5'h0);
    end
    // report pulse lasts one cycle: watch from the press on
    @(posedge clk);
    btn[0] <= 1'b1;
    hidw(1'b1, 3'h0);
    @(posedge clk);
    btn[0] <= 1'b0;
    hidw(1'b0, 3'h0);
    push(2, 1'b1);
    cmp({poe[5:4], pout[5:4]}, 4'hC);
    push(2, 1'b0);
    cmp({poe[5:4], pout[5:4]}, 4'hF);
    wr(PROFILE_OFS, 32'h5, AXI_OKAY);
    @(posedge clk);
    btn[3] <= 1'b1;
    savew(2'h0);
    push(3, 1'b0);
    @(posedge clk);
    btn[3] <= 1'b1;
    savew(2'h2);
    push(3, 1'b0);
  endtask
  task t_multi_press_button;
    wr(TAP_MAP_OFS, 32'h20, AXI_OKAY);
    wr(TAP_TIMING_OFS, 32'h000A0014, AXI_OKAY);
    @(posedge clk);
    btn[1] <= 1'b1;
    repeat (6) @(posedge clk);
    btn[1] <= 1'b0;
    hidw(1'b1, 3'h1);
    hidw(1'b0, 3'h1);
    @(posedge clk);
    ss <= 1'b1;
    @(posedge clk);
    ss <= 1'b0;
    @(posedge clk);
    cmp({apply, pidx}, 3'h6);
    // enable low freezes the block: a stream start is not seen
    @(posedge clk);
    ce <= 1'b0;
    ss <= 1'b1;
    @(posedge clk);
    ss <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    cmp(apply, 1'b0);
  endtask
  task complete_run;
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rq = '0;
    ce = 1'b1;
    att = 1'b1;
    bidle = 1'b0;
    aud = 1'b0;
    ser = 1'b0;
    pm = 1'b0;
    ss = 1'b0;
    nv = 2'h2;
    btn = 8'h0;
    rst_n = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_outs;
    t_buttons;
    t_multi_press_button;
    complete_run;
  end
  initial begin
    #200us;
    err_total++;
    complete_run;
  end
endmodule

// *** spf_pkg.sv ***
// constants and carrier types of the selectable pin function block
package spf_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] PIN_SEL_LO_OFS = 8'h00;
  localparam logic [7:0] PIN_SEL_HI_OFS = 8'h04;
  localparam logic [7:0] PIN_MODE_OFS = 8'h08;
  localparam logic [7:0] TAP_MAP_OFS = 8'h0C;
  localparam logic [7:0] DEBOUNCE_OFS = 8'h10;
  localparam logic [7:0] TAP_TIMING_OFS = 8'h14;
  localparam logic [7:0] PROFILE_OFS = 8'h18;
  localparam logic [7:0] AUDIO_CFG_OFS = 8'h1C;
  localparam logic [7:0] CFG_SIZE_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h24;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SEL_STRIDE = 8;
  localparam int SEL_W = 5;
  localparam int MODE_DIR_POS = 8;
  localparam int MODE_VAL_POS = 16;
  localparam int TIMING_GAP_POS = 16;
  localparam int PROFILE_IDX_POS = 4;
  localparam int AUDIO_ASYNC_POS = 4;
  localparam int STAT_SLEEP_POS = 8;
  localparam int STAT_SAVING_POS = 9;
  localparam int STAT_CAPT_POS = 10;
  localparam int STAT_PLAY_POS = 11;
  localparam int STAT_TAP_POS = 12;

  // ****************************************
  // reset values and limits
  // ****************************************
  localparam logic [15:0] DEBOUNCE_RST = 16'h2710;
  localparam logic [15:0] HOLD_RST = 16'hFFFF;
  localparam logic [15:0] GAP_RST = 16'h8000;
  localparam logic [3:0] PROFILE_MASK_RST = 4'h1;
  localparam logic [15:0] CFG_LIMIT = 16'h0AF0;
  localparam logic [3:0] STREAM_LAST = 4'h7;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ****************************************
  // pin function codes
  // ****************************************
  localparam logic [4:0] FN_NONE = 5'h00;
  localparam logic [4:0] FN_PLAY_PAUSE = 5'h01;
  localparam logic [4:0] FN_STOP = 5'h08;
  localparam logic [4:0] FN_CAPTURE_TOGGLE = 5'h09;
  localparam logic [4:0] FN_PROFILE_CYCLE = 5'h0A;
  localparam logic [4:0] FN_MULTI_PRESS = 5'h0B;
  localparam logic [4:0] FN_OUT_BASE = 5'h0C;
  localparam logic [4:0] FN_OUT_LAST = 5'h13;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    TAP_IDLE = 3'b001,
    TAP_DOWN = 3'b010,
    TAP_GAP = 3'b100
  } spf_tap_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } spf_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spf_axi_resp_type;

  typedef struct packed {
    logic valid;
    logic pressed;
    logic [2:0] usage;
  } spf_hid_type;

endpackage
